// file: hdl/sfd_pkg.sv
// Operation
// - 0x0000..0x1fff is the near region; direct form carries a 13-bit address field
// - beyond near region only indirect access, except move form with 16-bit address
// - all implemented data memory lies in the near region
// - addresses 0x0000..0x07ff form the special_function_register window
// - unused window addresses read zero and no register answers there
// - peripheral blocks are selected per 32-byte region holding at least one register
// - region split: core, notify, interrupts, timers, capture, compare, serial, analog
// - unimplemented bits of mapped registers read zero; hex reset values
// - small package: optional notify enable, pull-up and pull-down bits absent
// - byte write updates only the lane chosen by address bit zero
// - odd word access traps; faulting write suppressed, faulting read completes
// - reads outside implemented data memory return zero
package sfd_pkg;
  localparam logic [1:0]  MODE_INDIRECT = 2'h0;
  localparam logic [1:0]  MODE_NEAR     = 2'h1;
  localparam logic [1:0]  MODE_MOVE     = 2'h2;
  localparam int          NEAR_BITS     = 13;
  localparam logic [15:0] SFR_END       = 16'h0800;
  localparam logic [15:0] RAM_BASE      = 16'h0800;
  localparam int          RAM_WORDS_DEF = 256;
  localparam int          REGION_LSB    = 5;
  localparam int          NREGION       = 64;
  // one bit per 32-byte region of the window that holds registers
  localparam logic [63:0] SFR_IMPL_MAP  = 64'h0c02_0000_03c7_17ff;
  localparam logic [63:0] LOCAL_MAP     = 64'h0000_0000_0000_00f8;
  localparam int          ADDRERR_BIT   = 3;
  localparam int          NREG          = 25;
  localparam int          IDX_TRAP      = 6;
  localparam logic [10:0] REG_OFF [NREG] = '{
    11'h060, 11'h062, 11'h068, 11'h06a, 11'h070, 11'h072, 11'h080, 11'h082,
    11'h084, 11'h086, 11'h08a, 11'h08c, 11'h094, 11'h096, 11'h09a, 11'h09c,
    11'h0a4, 11'h0a6, 11'h0a8, 11'h0aa, 11'h0ac, 11'h0ae, 11'h0b2, 11'h0c4,
    11'h0e0};
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'h797f, 16'h60e0, 16'h797f, 16'h60e0, 16'h797f, 16'h60e0, 16'h801e, 16'hc007,
    16'hbf8f, 16'h201f, 16'h0000, 16'h2102, 16'hbf8f, 16'h201f, 16'h0000, 16'h2102,
    16'h7777, 16'h7000, 16'h7777, 16'h7077, 16'h7777, 16'h0007, 16'h0070, 16'h0070,
    16'haf7f};
  localparam logic [15:0] REG_OPT [NREG] = '{
    16'h6070, 16'h0080, 16'h6070, 16'h0080, 16'h6070, 16'h0080, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h4444, 16'h4444, 16'h4444, 16'h4044, 16'h4444, 16'h0004, 16'h4440, 16'h4440,
    16'h0000};
  // software-writable bits; the rest are set by hardware or mirror core state
  localparam logic [15:0] REG_WMASK [NREG] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'h0000};
  localparam logic        REG_LIVE [NREG] = '{
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
endpackage

// file: hdl/sfd_decoder.sv
`timescale 1ns/100ps
module sfd_decoder
  import sfd_pkg::*;
#(
  parameter int RAM_WORDS = RAM_WORDS_DEF,
  parameter bit SMALL_PKG = 1'b0
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 acc_rd_in,
  input  wire logic                 acc_wr_in,
  input  wire logic                 acc_byte_in,
  input  wire logic [1:0]           acc_mode_in,
  input  wire logic [15:0]          acc_addr_in,
  input  wire logic [15:0]          acc_wdata_in,
  output logic      [15:0]          acc_rdata_out,
  output logic                      acc_rvalid_out,
  output logic                      addr_err_out,
  output logic                      periph_sel_out,
  output logic      [5:0]           periph_region_out,
  output logic      [10:0]          periph_addr_out,
  output logic                      periph_wr_out,
  output logic      [1:0]           periph_lane_out,
  output logic      [15:0]          periph_wdata_out,
  input  wire logic [15:0]          periph_rdata_in,
  input  wire logic [NREG*16-1:0]   hw_set_in,
  output logic      [NREG*16-1:0]   reg_file_out
);

  logic [15:0]          ea;
  logic                 in_sfr;
  logic [5:0]           region;
  logic                 region_impl;
  logic                 region_local;
  logic [NREGION-1:0]   region_dec;
  logic                 misalign;
  logic                 access;
  logic                 wr_ok;
  logic [1:0]           lane;
  logic [15:0]          lane_mask;
  logic [15:0]          wdata_lanes;
  logic                 ram_hit;
  logic [15:0]          ram_off;
  logic [15:0]          ram_idx;
  logic [NREG-1:0]      reg_hit;
  logic [15:0]          local_rdata;
  logic [15:0]          word_rdata;
  logic [15:0]          acc_rdata_d;
  logic [15:0]          acc_rdata_q;
  logic                 acc_rvalid_q;
  logic                 addr_err_q;
  logic [15:0]          ram_q [RAM_WORDS];
  logic [15:0]          reg_q [NREG];

  // effective address: short direct form reaches only the near region
  always_comb begin
    if (acc_mode_in == MODE_NEAR) begin
      ea = {{(16 - NEAR_BITS){1'b0}}, acc_addr_in[NEAR_BITS-1:0]};
    end else begin
      ea = acc_addr_in;
    end
  end

  assign access       = acc_rd_in | acc_wr_in;
  assign in_sfr       = (ea < SFR_END);
  assign region       = ea[REGION_LSB+5:REGION_LSB];

  // one-hot 32-byte region decode inside the window
  genvar gr;
  generate
    for (gr = 0; gr < NREGION; gr++) begin : g_region
      assign region_dec[gr] = in_sfr && (region == 6'(gr));
    end
  endgenerate

  assign region_impl  = |(region_dec & SFR_IMPL_MAP);
  assign region_local = |(region_dec & LOCAL_MAP);
  assign misalign     = ~acc_byte_in & ea[0];
  assign wr_ok        = acc_wr_in & ~misalign;

  // byte lane selected by the low address bit
  always_comb begin
    if (acc_byte_in) begin
      lane        = ea[0] ? 2'b10 : 2'b01;
      wdata_lanes = {acc_wdata_in[7:0], acc_wdata_in[7:0]};
    end else begin
      lane        = 2'b11;
      wdata_lanes = acc_wdata_in;
    end
    lane_mask = {{8{lane[1]}}, {8{lane[0]}}};
  end

  // data memory sits above the window, inside the near region
  assign ram_off = ea - RAM_BASE;
  assign ram_idx = {1'b0, ram_off[15:1]};
  assign ram_hit = (ea >= RAM_BASE) && (ram_idx < 16'(RAM_WORDS));

  // peripheral strobe for implemented regions owned by other blocks
  assign periph_sel_out    = access & region_impl & ~region_local;
  assign periph_region_out = region;
  assign periph_addr_out   = ea[10:0];
  assign periph_wr_out     = wr_ok;
  assign periph_lane_out   = lane;
  assign periph_wdata_out  = wdata_lanes;

  // local register file for notify and interrupt regions
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      localparam logic [15:0] EFF_MASK = REG_MASK[gi] & (SMALL_PKG ? ~REG_OPT[gi] : 16'hffff);
      logic [15:0] set_bits;
      logic [15:0] we_bits;
      logic [15:0] reg_d;

      assign reg_hit[gi] = in_sfr && (ea[10:1] == REG_OFF[gi][10:1]);

      always_comb begin
        set_bits = hw_set_in[gi*16 +: 16];
        if (gi == IDX_TRAP && misalign && access) begin
          set_bits[ADDRERR_BIT] = 1'b1;
        end
        we_bits = (wr_ok && reg_hit[gi]) ? (lane_mask & REG_WMASK[gi]) : 16'h0000;
        if (REG_LIVE[gi]) begin
          reg_d = set_bits & EFF_MASK;
        end else begin
          // set wins over a simultaneous clear
          reg_d = ((reg_q[gi] & ~we_bits) | (wdata_lanes & we_bits) | set_bits)
                  & EFF_MASK;
        end
      end

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          reg_q[gi] <= REG_RST[gi] & EFF_MASK;
        end else begin
          reg_q[gi] <= reg_d;
        end
      end

      assign reg_file_out[gi*16 +: 16] = reg_q[gi];
    end
  endgenerate

  always_comb begin
    local_rdata = 16'h0000;
    for (int i = 0; i < NREG; i++) begin
      if (reg_hit[i]) begin
        local_rdata = local_rdata | reg_q[i];
      end
    end
  end

  // data memory write, lane by lane
  always_ff @(posedge clk_in) begin
    if (wr_ok && ram_hit) begin
      if (lane[0]) begin
        ram_q[ram_idx[$clog2(RAM_WORDS)-1:0]][7:0] <= wdata_lanes[7:0];
      end
      if (lane[1]) begin
        ram_q[ram_idx[$clog2(RAM_WORDS)-1:0]][15:8] <= wdata_lanes[15:8];
      end
    end
  end

  // read path: unmapped and out-of-range addresses read zero
  always_comb begin
    if (ram_hit) begin
      word_rdata = ram_q[ram_idx[$clog2(RAM_WORDS)-1:0]];
    end else if (region_local) begin
      word_rdata = local_rdata;
    end else if (region_impl) begin
      word_rdata = periph_rdata_in;
    end else begin
      word_rdata = 16'h0000;
    end
    if (acc_byte_in) begin
      acc_rdata_d = {8'h00, ea[0] ? word_rdata[15:8] : word_rdata[7:0]};
    end else begin
      acc_rdata_d = word_rdata;
    end
  end

  // a faulting read still returns its data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_rdata_q  <= 16'h0000;
      acc_rvalid_q <= 1'b0;
    end else begin
      acc_rvalid_q <= acc_rd_in;
      if (acc_rd_in) begin
        acc_rdata_q <= acc_rdata_d;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_err_q <= 1'b0;
    end else begin
      addr_err_q <= access & misalign;
    end
  end

  assign acc_rdata_out  = acc_rdata_q;
  assign acc_rvalid_out = acc_rvalid_q;
  assign addr_err_out   = addr_err_q;

endmodule

// file: dv/sfd_decoder_props.sv
`timescale 1ns/100ps
module sfd_decoder_props
  import sfd_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        acc_rd_in,
  input wire logic        acc_wr_in,
  input wire logic        acc_byte_in,
  input wire logic [1:0]  acc_mode_in,
  input wire logic [15:0] acc_addr_in,
  input wire logic [15:0] acc_wdata_in,
  input wire logic [15:0] acc_rdata_out,
  input wire logic        acc_rvalid_out,
  input wire logic        addr_err_out,
  input wire logic        periph_sel_out,
  input wire logic [5:0]  periph_region_out,
  input wire logic [10:0] periph_addr_out,
  input wire logic        periph_wr_out,
  input wire logic [1:0]  periph_lane_out,
  input wire logic [15:0] periph_wdata_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic mis;
  // word access at an odd address
  assign mis = (acc_rd_in || acc_wr_in) && !acc_byte_in && acc_addr_in[0];
  rd_valid_a: assert property (acc_rd_in |=> acc_rvalid_out)
    else $error("read gave no valid pulse");
  odd_err_a: assert property (mis |=> addr_err_out)
    else $error("odd word access did not trap");
  even_err_a: assert property (!mis |=> !addr_err_out)
    else $error("trap without odd word access");
  wr_drop_a: assert property (mis && acc_wr_in |-> !periph_wr_out)
    else $error("faulting write reached a peripheral");
  byte_lane_a: assert property (acc_wr_in && acc_byte_in |->
    periph_lane_out == (acc_addr_in[0] ? 2'h2 : 2'h1)) else $error("byte lane wrong");
  byte_data_a: assert property (acc_wr_in && acc_byte_in |->
    periph_wdata_out == {2{acc_wdata_in[7:0]}}) else $error("byte data not replicated");
  hole_zero_a: assert property (acc_rd_in && acc_addr_in[15:9] == 7'h02 |->
    !periph_sel_out ##1 acc_rdata_out == 16'h0000) else $error("unused address answered");
  high_zero_a: assert property (acc_rd_in && acc_addr_in[15] &&
    acc_mode_in != MODE_NEAR |=> acc_rdata_out == 16'h0000) else $error("outside read not zero");
  region_sel_a: assert property (acc_rd_in && acc_addr_in[15:5] == 11'h011 |->
    periph_sel_out && periph_region_out == 6'h11 && periph_addr_out == acc_addr_in[10:0])
    else $error("serial region not selected");
  local_hold_a: assert property (acc_rd_in && acc_addr_in[15:7] == 9'h001 |->
    !periph_sel_out) else $error("local register region reached a peripheral");
  cover property (acc_rd_in && periph_sel_out);
  cover property (mis && acc_wr_in);
  cover property (acc_wr_in && acc_byte_in);
endmodule
bind sfd_decoder sfd_decoder_props chk (
  .clk_in            (clk_in),
  .rst_in            (rst_in),
  .acc_rd_in         (acc_rd_in),
  .acc_wr_in         (acc_wr_in),
  .acc_byte_in       (acc_byte_in),
  .acc_mode_in       (acc_mode_in),
  .acc_addr_in       (acc_addr_in),
  .acc_wdata_in      (acc_wdata_in),
  .acc_rdata_out     (acc_rdata_out),
  .acc_rvalid_out    (acc_rvalid_out),
  .addr_err_out      (addr_err_out),
  .periph_sel_out    (periph_sel_out),
  .periph_region_out (periph_region_out),
  .periph_addr_out   (periph_addr_out),
  .periph_wr_out     (periph_wr_out),
  .periph_lane_out   (periph_lane_out),
  .periph_wdata_out  (periph_wdata_out)
);

// file: dv/sfd_periph_model.sv
`timescale 1ns/100ps
module sfd_periph_model (
  input  wire logic        clk_in,
  input  wire logic        sel_in,
  input  wire logic        wr_in,
  input  wire logic [1:0]  lane_in,
  input  wire logic [10:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem_q [1024];
  logic [15:0] last_q = 16'h0000;
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (sel_in && wr_in && lane_in[i]) mem_q[addr_in[10:1]][i*8+:8] <= wdata_in[i*8+:8];
    end
    last_q <= rdata_out;
  end
  // deselected bus toggles rather than holding the last value
  assign rdata_out = sel_in ? mem_q[addr_in[10:1]] : ~last_q;
endmodule

// file: dv/sfr_space_decoder_bench.sv
`timescale 1ns/100ps
module sfr_space_decoder_bench;
  logic        clk_in = 1'b0, rst_in = 1'b1, acc_rd_in = 1'b0, acc_wr_in = 1'b0;
  logic        acc_byte_in = 1'b0, acc_rvalid_out, addr_err_out, periph_sel_out, periph_wr_out;
  logic [1:0]  acc_mode_in = 2'h0, periph_lane_out;
  logic [5:0]  periph_region_out;
  logic [10:0] periph_addr_out;
  logic [15:0] acc_addr_in = 16'h0000, acc_wdata_in = 16'h0000;
  logic [15:0] acc_rdata_out, periph_wdata_out, periph_rdata_in;
  int          mismatches = 0, n_checks = 0;
  logic [15:0] small_rdata;
  logic [sfd_pkg::NREG*16-1:0] hw_set = '0;
  // ctl nibble {wr, rd, byte, trap expected}, mode, address, write data or read result
  localparam logic [39:0] ROWS [18] = '{
    40'h4_0_00a6_4000, 40'h4_1_00ae_0004, 40'h4_2_00b2_0040,
    40'h8_0_0094_ffff, 40'h4_0_0094_bf8f, 40'ha_0_0097_00ff,
    40'h4_0_0096_2000, 40'h6_0_0097_0020, 40'h9_0_0085_ffff,
    40'h4_0_0084_0000, 40'h5_0_0081_0008, 40'h4_2_0400_0000,
    40'h8_2_0800_1234, 40'h4_1_e800_1234, 40'h4_0_8800_0000,
    40'h4_3_0a00_0000, 40'h8_0_0220_beef, 40'h6_0_0221_00be};
  always #50 clk_in = ~clk_in;
  sfd_decoder DUT (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .acc_rd_in         (acc_rd_in),
    .acc_wr_in         (acc_wr_in),
    .acc_byte_in       (acc_byte_in),
    .acc_mode_in       (acc_mode_in),
    .acc_addr_in       (acc_addr_in),
    .acc_wdata_in      (acc_wdata_in),
    .acc_rdata_out     (acc_rdata_out),
    .acc_rvalid_out    (acc_rvalid_out),
    .addr_err_out      (addr_err_out),
    .periph_sel_out    (periph_sel_out),
    .periph_region_out (periph_region_out),
    .periph_addr_out   (periph_addr_out),
    .periph_wr_out     (periph_wr_out),
    .periph_lane_out   (periph_lane_out),
    .periph_wdata_out  (periph_wdata_out),
    .periph_rdata_in   (periph_rdata_in),
    .hw_set_in         (hw_set),
    .reg_file_out      ()
  );
  // small package variant, optional notify bits absent
  sfd_decoder #(.SMALL_PKG(1'b1)) DUT_SMALL (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .acc_rd_in         (acc_rd_in),
    .acc_wr_in         (acc_wr_in),
    .acc_byte_in       (acc_byte_in),
    .acc_mode_in       (acc_mode_in),
    .acc_addr_in       (acc_addr_in),
    .acc_wdata_in      (acc_wdata_in),
    .acc_rdata_out     (small_rdata),
    .acc_rvalid_out    (),
    .addr_err_out      (),
    .periph_sel_out    (),
    .periph_region_out (),
    .periph_addr_out   (),
    .periph_wr_out     (),
    .periph_lane_out   (),
    .periph_wdata_out  (),
    .periph_rdata_in   (16'h0000),
    .hw_set_in         ('0),
    .reg_file_out      ()
  );
  sfd_periph_model peri (.clk_in(clk_in), .sel_in(periph_sel_out), .wr_in(periph_wr_out),
    .lane_in(periph_lane_out), .addr_in(periph_addr_out), .wdata_in(periph_wdata_out),
    .rdata_out(periph_rdata_in));
  task automatic op(input logic [3:0] c, input logic [1:0] m, input logic [15:0] a,
                    input logic [15:0] d);
    acc_wr_in = c[3];
    acc_rd_in = c[2];
    acc_byte_in = c[1];
    acc_mode_in = m;
    acc_addr_in = a;
    acc_wdata_in = d;
    @(negedge clk_in);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    foreach (ROWS[i]) begin
      op(ROWS[i][39:36], ROWS[i][33:32], ROWS[i][31:16], ROWS[i][15:0]);
      if (ROWS[i][38]) chk(acc_rdata_out, ROWS[i][15:0]);
      chk({15'h0000, addr_err_out}, {15'h0000, ROWS[i][36]});
    end
    // hardware set and software clear in one cycle: the set wins
    hw_set[8*16 +: 16] = 16'h0001;
    op(4'h8, 2'h0, 16'h0084, 16'h0000);
    hw_set = '0;
    op(4'h4, 2'h0, 16'h0084, 16'h0000);
    chk(acc_rdata_out, 16'h0001);
    // live vector register shows only its implemented bits
    hw_set[24*16 +: 16] = 16'hffff;
    op(4'h0, 2'h0, 16'h0000, 16'h0000);
    op(4'h4, 2'h0, 16'h00e0, 16'h0000);
    chk(acc_rdata_out, 16'haf7f);
    hw_set = '0;
    op(4'h8, 2'h0, 16'h0060, 16'hffff);
    op(4'h4, 2'h0, 16'h0060, 16'h0000);
    chk(acc_rdata_out, 16'h797f);
    chk(small_rdata, 16'h190f);
    op(4'h8, 2'h0, 16'h00a4, 16'h0000);
    op(4'h4, 2'h0, 16'h00a4, 16'h0000);
    chk(acc_rdata_out, 16'h0000);
    rst_in = 1'b1;
    repeat (2) op(4'h0, 2'h0, 16'h0000, 16'h0000);
    chk(acc_rdata_out, 16'h0000);
    rst_in = 1'b0;
    op(4'h4, 2'h0, 16'h00a4, 16'h0000);
    chk(acc_rdata_out, 16'h4444);
    op(4'h0, 2'h0, 16'h0000, 16'h0000);
    end_of_test();
  end
endmodule
